// [pkg/lpr_pkg.sv]
// Package with register map, reset values and timing for the polarity block.
package lpr_pkg;

  localparam logic [7:0] LPR_ADDR_SNAPSHOT  = 8'h26;
  localparam logic [7:0] LPR_ADDR_PROGRAMMED = 8'h1d;
  localparam logic [7:0] LPR_ADDR_ACTIVE    = 8'h23;
  localparam logic [7:0] LPR_ADDR_PRODUCT   = 8'hfd;
  localparam logic [7:0] LPR_ADDR_MAKER     = 8'hfe;
  localparam logic [7:0] LPR_ADDR_REVISION  = 8'hff;

  localparam logic [7:0] LPR_RST_POLARITY = 8'h00;

  // Field positions: sense bipolar bits 7..4, bus bipolar bits 3..0.
  localparam int LPR_SENSE_LSB = 4;
  localparam int LPR_BUS_LSB   = 0;

  // Result registers become valid this long after an update command.
  localparam int LPR_VALID_TIME_US = 1000;
  localparam int LPR_CLK_MHZ       = 100;
  localparam int LPR_VALID_CYCLES  = LPR_VALID_TIME_US * LPR_CLK_MHZ;

endpackage : lpr_pkg

// [hw/lpr_valid_timer.sv]
// Counter that marks the snapshot valid a fixed time after an update.
`timescale 1ns/1ps
module lpr_valid_timer #(
  parameter int CYCLES = 100000
) (
  input  wire logic mclk,   // System clock.
  input  wire logic rst,    // Synchronous reset, active high.
  input  wire logic start,  // Restart the wait.
  output logic      valid   // High once the wait has elapsed.
);
  localparam int CW = $clog2(CYCLES + 1);

  initial begin
    if (CYCLES < 1) $error("lpr_valid_timer: CYCLES must be at least 1");
  end

  logic [CW-1:0] count;

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= '0;
      valid <= 1'b0;
    end else if (start) begin
      count <= CW'(CYCLES - 1);
      valid <= 1'b0;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end else begin
      valid <= 1'b1;
    end
  end
endmodule // lpr_valid_timer

// [hw/lpr_regs.sv]
// Latched polarity and identification register slice.
//
// Overview of operation
// - Every update command variant copies the prior active setting into the snapshot.
// - Programmed setting takes effect only at an update; active holds it.
// - Snapshot is valid one millisecond after any update command.
// - Bits 7..4 are sense channels 1..4; set means bipolar two's complement.
// - Bits 3..0 are bus channels 1..4; set means bipolar two's complement.
// - Product code always readable, writable only in test mode.
// - Maker code is a fixed read-only byte.
// - Revision code is a fixed read-only byte.
`timescale 1ns/1ps
module lpr_regs #(
  parameter logic [7:0] PRODUCT_CODE  = 8'h01, // Arbitrary value.
  parameter logic [7:0] MAKER_CODE    = 8'h02, // Arbitrary value.
  parameter logic [7:0] REVISION_CODE = 8'h04, // Arbitrary value.
  parameter int         VALID_CYCLES  = lpr_pkg::LPR_VALID_CYCLES
) (
  input  wire logic       mclk,            // System clock, 100 MHz.
  input  wire logic       rst,             // Synchronous reset, active high.
  input  wire logic [7:0] addr,            // Register address.
  input  wire logic [7:0] wdata,           // Write data.
  input  wire logic       wr,              // Write strobe.
  input  wire logic       rd,              // Read strobe.
  output logic      [7:0] rdata,           // Read data, cycle after rd.
  input  wire logic       test_unlock,     // Test mode unlocked.
  input  wire logic       update_cmd,      // Any update command variant.
  output logic      [7:0] active_polarity_setting, // Settings in force.
  output logic      [3:0] sense_bipolar,   // Snapshot sense bits, ch1..4.
  output logic      [3:0] bus_bipolar,     // Snapshot bus bits, ch1..4.
  output logic            snapshot_valid   // Snapshot results valid.
);

  initial begin
    if (VALID_CYCLES < 1) $error("lpr_regs: VALID_CYCLES must be >= 1");
  end

  logic [7:0] programmed_polarity_setting;
  logic [7:0] latched_polarity_snapshot;
  logic [7:0] product_code_field;
  logic [7:0] next_rdata;
  logic       timer_valid;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // Programmed setting is staged by the host and has no effect on its own.
  // Writes are gated by test unlock so a stray write cannot disturb it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      programmed_polarity_setting <= lpr_pkg::LPR_RST_POLARITY;
    end else if (wr && test_unlock &&
                 hit(addr, lpr_pkg::LPR_ADDR_PROGRAMMED)) begin
      programmed_polarity_setting <= wdata;
    end
  end

  // Active takes the programmed value only on an update; snapshot keeps the
  // value active just before, matching the dataset of that conversion.
  always_ff @(posedge mclk) begin
    if (rst) begin
      active_polarity_setting   <= lpr_pkg::LPR_RST_POLARITY;
      latched_polarity_snapshot <= lpr_pkg::LPR_RST_POLARITY;
    end else if (update_cmd) begin
      active_polarity_setting   <= programmed_polarity_setting;
      latched_polarity_snapshot <= active_polarity_setting;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      product_code_field <= PRODUCT_CODE;
    end else if (wr && test_unlock &&
                 hit(addr, lpr_pkg::LPR_ADDR_PRODUCT)) begin
      product_code_field <= wdata;
    end
  end

  lpr_valid_timer #(
    .CYCLES(VALID_CYCLES)
  ) u_timer (
    .mclk  (mclk),
    .rst   (rst),
    .start (update_cmd),
    .valid (timer_valid)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      snapshot_valid <= 1'b0;
      sense_bipolar  <= '0;
      bus_bipolar    <= '0;
    end else begin
      snapshot_valid <= timer_valid && !update_cmd;
      sense_bipolar  <= latched_polarity_snapshot[
                          lpr_pkg::LPR_SENSE_LSB +: 4];
      bus_bipolar    <= latched_polarity_snapshot[
                          lpr_pkg::LPR_BUS_LSB +: 4];
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (hit(addr, lpr_pkg::LPR_ADDR_SNAPSHOT)) begin
      next_rdata = latched_polarity_snapshot;
    end else if (hit(addr, lpr_pkg::LPR_ADDR_ACTIVE)) begin
      next_rdata = active_polarity_setting;
    end else if (hit(addr, lpr_pkg::LPR_ADDR_PROGRAMMED)) begin
      next_rdata = programmed_polarity_setting;
    end else if (hit(addr, lpr_pkg::LPR_ADDR_PRODUCT)) begin
      next_rdata = product_code_field;
    end else if (hit(addr, lpr_pkg::LPR_ADDR_MAKER)) begin
      next_rdata = MAKER_CODE;
    end else if (hit(addr, lpr_pkg::LPR_ADDR_REVISION)) begin
      next_rdata = REVISION_CODE;
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // True for every address that this slice answers on reads.
  function automatic logic is_mapped(input logic [7:0] a);
    return hit(a, lpr_pkg::LPR_ADDR_SNAPSHOT) ||
           hit(a, lpr_pkg::LPR_ADDR_ACTIVE) ||
           hit(a, lpr_pkg::LPR_ADDR_PROGRAMMED) ||
           hit(a, lpr_pkg::LPR_ADDR_PRODUCT) ||
           hit(a, lpr_pkg::LPR_ADDR_MAKER) ||
           hit(a, lpr_pkg::LPR_ADDR_REVISION);
  endfunction

  // Cycles since the last update, all ones from reset to the first update; counts up from zero and saturates at all ones.
  // Valid timing is checked against this count, not against the timer.
  logic [31:0] since_update;

  always_ff @(posedge mclk) begin
    if (rst) begin
      since_update <= 32'hffff_ffff;
    end else if (update_cmd) begin
      since_update <= 32'h0000_0000;
    end else if (since_update != 32'hffff_ffff) begin
      since_update <= since_update + 32'h0000_0001;
    end
  end

  a_snapshot_prior: assert property (@(posedge mclk) disable iff (rst)
    update_cmd |=> latched_polarity_snapshot == $past(active_polarity_setting))
    else $error("snapshot did not take prior active value");

  a_active_update: assert property (@(posedge mclk) disable iff (rst)
    update_cmd |=> active_polarity_setting ==
                   $past(programmed_polarity_setting))
    else $error("active did not take programmed value");

  a_active_hold: assert property (@(posedge mclk) disable iff (rst)
    !update_cmd |=> $stable(active_polarity_setting))
    else $error("active changed without update");

  a_valid_clear: assert property (@(posedge mclk) disable iff (rst)
    update_cmd |=> !snapshot_valid [*8])
    else $error("snapshot valid too early");

  a_sense_map: assert property (@(posedge mclk) disable iff (rst)
    sense_bipolar == $past(latched_polarity_snapshot[7:4]))
    else $error("sense bit mapping wrong");

  a_bus_map: assert property (@(posedge mclk) disable iff (rst)
    bus_bipolar == $past(latched_polarity_snapshot[3:0]))
    else $error("bus bit mapping wrong");

  a_product_lock: assert property (@(posedge mclk) disable iff (rst)
    (wr && !test_unlock) |=> $stable(product_code_field))
    else $error("product code written while locked");

  a_maker_read: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == lpr_pkg::LPR_ADDR_MAKER) |=> rdata == MAKER_CODE)
    else $error("maker code read wrong");

  a_revision_read: assert property (@(posedge mclk) disable iff (rst)
    (rd && addr == lpr_pkg::LPR_ADDR_REVISION) |=> rdata == REVISION_CODE)
    else $error("revision code read wrong");

  a_locked_write: assert property (@(posedge mclk) disable iff (rst)
    (wr && !test_unlock && !update_cmd) |=>
      $stable(programmed_polarity_setting) &&
      $stable(latched_polarity_snapshot))
    else $error("register changed by locked write");

  // Read path: data stands one cycle after the strobe, zero elsewhere.
  a_rdata_idle: assert property (
    @(posedge mclk) disable iff (rst) !rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

  a_unmapped_read: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && !is_mapped(addr)) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  a_snapshot_read: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && hit(addr, lpr_pkg::LPR_ADDR_SNAPSHOT)) |=>
      rdata == $past(latched_polarity_snapshot))
    else $error("snapshot read wrong");

  a_active_read: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && hit(addr, lpr_pkg::LPR_ADDR_ACTIVE)) |=>
      rdata == $past(active_polarity_setting))
    else $error("active read wrong");

  a_programmed_read: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && hit(addr, lpr_pkg::LPR_ADDR_PROGRAMMED)) |=>
      rdata == $past(programmed_polarity_setting))
    else $error("programmed read wrong");

  a_product_read: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && hit(addr, lpr_pkg::LPR_ADDR_PRODUCT)) |=>
      rdata == $past(product_code_field))
    else $error("product read wrong");

  a_product_locked_read: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && !test_unlock && hit(addr, lpr_pkg::LPR_ADDR_PRODUCT)) |=>
      rdata == $past(product_code_field))
    else $error("product not readable while locked");

  a_maker_unlocked: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && test_unlock && hit(addr, lpr_pkg::LPR_ADDR_MAKER)) |=>
      rdata == MAKER_CODE)
    else $error("maker code changed in test mode");

  a_revision_unlocked: assert property (
    @(posedge mclk) disable iff (rst)
    (rd && test_unlock && hit(addr, lpr_pkg::LPR_ADDR_REVISION)) |=>
      rdata == REVISION_CODE)
    else $error("revision code changed in test mode");

  // Write path: only unlocked writes to the two writable bytes land, and
  // the snapshot and active bytes never take host data.
  a_programmed_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && test_unlock && hit(addr, lpr_pkg::LPR_ADDR_PROGRAMMED)) |=>
      programmed_polarity_setting == $past(wdata))
    else $error("programmed write lost");

  a_programmed_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !(wr && test_unlock && hit(addr, lpr_pkg::LPR_ADDR_PROGRAMMED)) |=>
      $stable(programmed_polarity_setting))
    else $error("programmed changed without write");

  a_product_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && test_unlock && hit(addr, lpr_pkg::LPR_ADDR_PRODUCT)) |=>
      product_code_field == $past(wdata))
    else $error("product write lost in test mode");

  a_product_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !(wr && test_unlock && hit(addr, lpr_pkg::LPR_ADDR_PRODUCT)) |=>
      $stable(product_code_field))
    else $error("product changed without write");

  a_snapshot_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && !update_cmd && hit(addr, lpr_pkg::LPR_ADDR_SNAPSHOT)) |=>
      $stable(latched_polarity_snapshot))
    else $error("snapshot took host data");

  a_active_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && !update_cmd && hit(addr, lpr_pkg::LPR_ADDR_ACTIVE)) |=>
      $stable(active_polarity_setting))
    else $error("active took host data");

  a_active_locked: assert property (
    @(posedge mclk) disable iff (rst)
    (wr && !test_unlock && !update_cmd) |=>
      $stable(active_polarity_setting))
    else $error("active changed by locked write");

  // Reset clears state one edge later, whatever else is on the bus.
  a_reset_state: assert property (
    @(posedge mclk)
    rst |=> rdata == 8'h00 &&
            active_polarity_setting == lpr_pkg::LPR_RST_POLARITY &&
            latched_polarity_snapshot == lpr_pkg::LPR_RST_POLARITY &&
            !snapshot_valid)
    else $error("state not cleared by reset");

  a_product_reset: assert property (
    @(posedge mclk) rst |=> product_code_field == PRODUCT_CODE)
    else $error("product code not restored by reset");

  // Valid must stay low for the whole wait and rise exactly when it ends;
  // a host that polls too early would otherwise read a mixed dataset.
  a_valid_early: assert property (
    @(posedge mclk) disable iff (rst)
    (since_update <= 32'(VALID_CYCLES)) |-> !snapshot_valid)
    else $error("snapshot valid before the wait ended");

  a_valid_due: assert property (
    @(posedge mclk) disable iff (rst)
    (since_update == 32'(VALID_CYCLES + 1)) |-> snapshot_valid)
    else $error("snapshot valid late");

  a_valid_set: assert property (
    @(posedge mclk) disable iff (rst)
    (timer_valid && !update_cmd) |=> snapshot_valid)
    else $error("snapshot valid not following timer");

  a_valid_hold: assert property (
    @(posedge mclk) disable iff (rst)
    (snapshot_valid && !update_cmd) |=> snapshot_valid)
    else $error("snapshot valid dropped without update");

  a_timer_restart: assert property (
    @(posedge mclk) disable iff (rst)
    update_cmd |=> !timer_valid)
    else $error("timer not restarted by update");

  // Field checks tie each half of the snapshot and each output to the
  // setting that was in force before the update.
  a_sense_field: assert property (
    @(posedge mclk) disable iff (rst)
    $past(update_cmd) |->
      latched_polarity_snapshot[7:4] == $past(active_polarity_setting[7:4]))
    else $error("sense field not latched");

  a_bus_field: assert property (
    @(posedge mclk) disable iff (rst)
    $past(update_cmd) |->
      latched_polarity_snapshot[3:0] == $past(active_polarity_setting[3:0]))
    else $error("bus field not latched");

  a_sense_lag: assert property (
    @(posedge mclk) disable iff (rst)
    $past(update_cmd, 2) |->
      sense_bipolar == $past(active_polarity_setting[7:4], 2))
    else $error("sense outputs not from prior setting");

  a_bus_lag: assert property (
    @(posedge mclk) disable iff (rst)
    $past(update_cmd, 2) |->
      bus_bipolar == $past(active_polarity_setting[3:0], 2))
    else $error("bus outputs not from prior setting");

endmodule // lpr_regs

// [verification/lpr_host.sv]
// Host model that drives the register port of the polarity block.
`timescale 1ns/1ps
module lpr_host (
  input  wire logic       mclk,  // System clock.
  output logic      [7:0] addr,  // Register address.
  output logic      [7:0] wdata, // Write data.
  output logic            wr,    // Write strobe.
  output logic            rd,    // Read strobe.
  input  wire logic [7:0] rdata  // Read data.
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    // Idle data is inverted so that a stale bus cannot pass for a write.
    wdata <= ~d;
  endtask

  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // lpr_host

// [verification/lpr_regs_bench.sv]
// Self-checking bench for the polarity and identification registers.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module lpr_regs_bench;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr, wdata, rdata, active, v;
  logic       wr, rd, test_unlock, update_cmd, valid;
  logic [3:0] sense, bus;
  logic [7:0] locked_addr [5] = '{8'hfd, 8'hfe, 8'hff, 8'h26, 8'h1d};
  int         err_total = 0;
  int         checks_done = 0;
  int         cycles = 0;

  always #5 mclk = ~mclk;

  lpr_host u_host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  // A short wait keeps the valid delay cheap to simulate.
  lpr_regs #(.VALID_CYCLES(10)) u_dut (.mclk(mclk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .test_unlock(test_unlock), .update_cmd(update_cmd),
    .active_polarity_setting(active), .sense_bipolar(sense),
    .bus_bipolar(bus), .snapshot_valid(valid));

  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    u_host.get(a, v);
    `CHK(v, e)
  endtask

  task automatic pulse_update();
    @(posedge mclk);
    update_cmd <= 1'b1;
    @(posedge mclk);
    update_cmd <= 1'b0;
    #1 `CHK(valid, 1'b0)
  endtask

  task automatic check_idle();
    expect_reg(8'h26, 8'h00);
    expect_reg(8'hfd, 8'h01);
    expect_reg(8'hfe, 8'h02);
    expect_reg(8'hff, 8'h04);
    expect_reg(8'h00, 8'h00);
  endtask

  task automatic check_locked();
    foreach (locked_addr[i]) u_host.put(locked_addr[i], 8'hff);
    check_idle();
    pulse_update();
    expect_reg(8'h23, 8'h00);
  endtask

  task automatic check_update();
    @(posedge mclk);
    test_unlock <= 1'b1;
    u_host.put(8'hfd, 8'h77);
    expect_reg(8'hfd, 8'h77);
    u_host.put(8'hfe, 8'h77);
    expect_reg(8'hfe, 8'h02);
    u_host.put(8'h1d, 8'ha5);
    expect_reg(8'h23, 8'h00);
    pulse_update();
    expect_reg(8'h23, 8'ha5);
    expect_reg(8'h26, 8'h00);
    u_host.put(8'h1d, 8'h3c);
    pulse_update();
    `CHK(valid, 1'b0)
    repeat (12) @(posedge mclk);
    #1 `CHK(valid, 1'b1)
    u_host.put(8'h26, 8'h55);
    u_host.put(8'h23, 8'h55);
    u_host.put(8'hff, 8'h77);
    expect_reg(8'hff, 8'h04);
    expect_reg(8'h26, 8'ha5);
    `CHK({sense, bus}, 8'ha5)
    expect_reg(8'h23, 8'h3c);
    `CHK(active, 8'h3c)
  endtask

  task automatic check_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 `CHK(valid, 1'b0)
    `CHK(active, 8'h00)
    expect_reg(8'h26, 8'h00);
    expect_reg(8'hfd, 8'h01);
  endtask

  initial begin
    test_unlock = 1'b0;
    update_cmd = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    check_idle();
    check_locked();
    check_update();
    check_reset();
    wrap_up();
  end
endmodule // lpr_regs_bench
